// [pkg/ump_pkg.sv]
// ump_pkg: shared offsets, fields, timing constants, types and helpers of the serial port
package ump_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0]  OFS_DATA   = 8'h00;
  localparam logic [7:0]  OFS_CSRA   = 8'h04;
  localparam logic [7:0]  OFS_CSRB   = 8'h08;
  localparam logic [7:0]  OFS_CSRC   = 8'h0C;
  localparam logic [7:0]  OFS_BAUD   = 8'h10;

  // serial_ctrl_status_a field positions
  localparam int          CSRA_RXC   = 7;
  localparam int          CSRA_TXC   = 6;
  localparam int          CSRA_TX_BUFFER_EMPTY_FLAG  = 5;
  localparam int          CSRA_FE    = 4;
  localparam int          CSRA_DOR   = 3;
  localparam int          CSRA_UPE   = 2;
  localparam int          CSRA_DSPD  = 1;
  localparam int          CSRA_MPF   = 0;

  // control b and control c field positions
  localparam int          CSRB_RXEN  = 4;
  localparam int          CSRB_TXEN  = 3;
  localparam int          CSRB_CSZ2  = 2;
  localparam int          CSRB_RX9   = 1;
  localparam int          CSRB_TX9   = 0;
  localparam int          CSRC_PEN   = 5;
  localparam int          CSRC_PODD  = 4;
  localparam int          CSRC_STOP2 = 3;
  localparam int          CSRC_CSZLO = 1;

  // reset values and writable-bit masks
  localparam logic [7:0]  CSRA_RST   = 8'h20;
  localparam logic [7:0]  CSRB_RST   = 8'h00;
  localparam logic [7:0]  CSRC_RST   = 8'h06;
  localparam logic [11:0] BAUD_RST   = 12'h000;
  localparam logic [7:0]  CSRA_WMASK = 8'h03;
  localparam logic [7:0]  CSRB_WMASK = 8'h1D;
  localparam logic [7:0]  CSRC_WMASK = 8'h3E;

  // oversampling rates and middle voting sample
  localparam logic [4:0]  OVS_NORMAL  = 5'h10;
  localparam logic [4:0]  OVS_DOUBLE  = 5'h08;
  localparam logic [4:0]  VOTE_NORMAL = 5'h08;
  localparam logic [4:0]  VOTE_DOUBLE = 5'h04;

  // character size code for nine data bits, fixed peer frame length
  localparam logic [2:0]  CSZ_NINE        = 3'h7;
  localparam logic [3:0]  PEER_FRAME_BITS = 4'hB;

  // accepted incoming rate, hundredths of a percent, eight data-plus-parity bits
  localparam int          RX_SLOW_NORMAL = 9536;
  localparam int          RX_FAST_NORMAL = 10458;
  localparam int          RX_SLOW_DOUBLE = 9600;
  localparam int          RX_FAST_DOUBLE = 10390;

  typedef enum logic [1:0] {
    UMP_RX_IDLE  = 2'h0,
    UMP_RX_START = 2'h1,
    UMP_RX_BITS  = 2'h3
  } ump_rx_state_e;

  typedef enum logic {
    UMP_TX_IDLE  = 1'b0,
    UMP_TX_SHIFT = 1'b1
  } ump_tx_state_e;

  // number of data bits for a character size code
  function automatic logic [3:0] ump_data_bits(input logic [2:0] csz);
    ump_data_bits = (csz == CSZ_NINE) ? 4'h9 : 4'h5 + {2'h0, csz[1:0]};
  endfunction

  // mask of the used data bits for a character size code
  function automatic logic [8:0] ump_char_mask(input logic [2:0] csz);
    logic [3:0] nb;
    nb = ump_data_bits(csz);
    for (int i = 0; i < 9; i++) begin
      ump_char_mask[i] = (4'(i) < nb);
    end
  endfunction

endpackage

// [pkg/ump_link_if.sv]
// ump_link_if: serial lines between the port and a peer controller
`timescale 1ns/1ps
interface ump_link_if;
  logic dev_txd;
  logic peer_txd;
  modport dev  (output dev_txd, input peer_txd);
  modport peer (input dev_txd, output peer_txd);
endinterface

// [rtl/ump_baud_gen.sv]
// ump_baud_gen: oversampling tick divider, one tick every div_i+1 clocks
`timescale 1ns/1ps
module ump_baud_gen (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic [11:0] div_i,
  output logic             tick_o
);
  logic [11:0] cnt;

  // reload on zero, count down otherwise
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= 12'h000;
      tick_o <= 1'b0;
    end else if (!en_i) begin
      cnt    <= 12'h000;
      tick_o <= 1'b0;
    end else if (cnt == 12'h000) begin
      cnt    <= div_i;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt - 12'h001;
      tick_o <= 1'b0;
    end
  end
endmodule

// [rtl/ump_peer.sv]
// ump_peer: bus master controller sending address and data frames on the shared line
`timescale 1ns/1ps
module ump_peer (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [11:0] baud_div_i,
  input  wire logic        send_i,
  input  wire logic        addr_frame_i,
  input  wire logic [7:0]  data_i,
  output logic             ready_o,
  ump_link_if.peer         link
);
  import ump_pkg::*;

  ump_tx_state_e state;
  logic [10:0]   sr;
  logic [3:0]    left;
  logic [4:0]    os;
  logic          os_tick;

  ump_baud_gen u_baud (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .en_i      (1'b1),
    .div_i     (baud_div_i),
    .tick_o    (os_tick)
  );

  // accept a frame only while idle
  assign ready_o      = (state == UMP_TX_IDLE);
  assign link.peer_txd = sr[0];

  // frame: start, eight data, type bit, closing stop
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= UMP_TX_IDLE;
      sr    <= 11'h7FF;
      left  <= 4'h0;
      os    <= 5'h00;
    end else if (send_i && ready_o) begin
      // [R7] ninth bit marks address
      // [R9] type bit, then second stop
      sr    <= {1'b1, addr_frame_i, data_i, 1'b0};
      left  <= PEER_FRAME_BITS;
      os    <= 5'h00;
      state <= UMP_TX_SHIFT;
    end else if (state == UMP_TX_SHIFT && os_tick) begin
      os <= (os == OVS_NORMAL - 5'h01) ? 5'h00 : os + 5'h01;
      if (os == OVS_NORMAL - 5'h01) begin
        sr   <= {1'b1, sr[10:1]};
        left <= left - 4'h1;
        if (left == 4'h1) begin
          state <= UMP_TX_IDLE;
        end
      end
    end
  end
endmodule

// [rtl/ump_usart.sv]
// ump_usart: serial port with multiprocessor filter, data port, two-entry receive fifo
// Functional notes
// [R1] filter on: drop frames not marked address
// [R2] transmitter ignores the filter setting
// [R3] five to eight bits: first stop is type
// [R4] nine bits: ninth data bit is type
// [R5] type one is address, zero is data
// [R6] accepted address frame stored like any frame
// [R7] master sends nine bits, ninth marks address
// [R8] slave software toggles filter per address match
// [R9] short frames with filtering need two stops
// [R10] no read-modify-write on filter enable
// [R11] data port: write transmit, read receive
// [R12] unused upper bits ignored, read as zero
// [R13] write while buffer full is ignored
// [R14] buffered data loads into empty shifter
// [R15] two-entry receive fifo pops on reads
// [R16] receive complete while fifo holds data
// [R17] receiver disable flushes the fifo
// [R18] normal speed tolerates 95.36 to 104.58 percent
// [R19] double speed tolerates 96.00 to 103.90 percent
// [R20] sample at 16x, 8x double speed
// [R21] transmit complete set when idle, write-one clears
// [R22] dropped frames touch no error flags
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module ump_usart (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  ump_link_if.dev          link
);
  import ump_pkg::*;

  logic [7:0]    ctl_a;
  logic [7:0]    ctl_b;
  logic [7:0]    ctl_c;
  logic [11:0]   baud_div;
  logic          tx_complete_flag;
  logic          overrun_flag;
  logic          os_tick;
  ump_rx_state_e rx_state;
  logic [4:0]    rx_cnt;
  logic [3:0]    rx_idx;
  logic [1:0]    rx_win;
  logic [10:0]   rx_bits;
  logic [10:0]   rx_mem [2];
  logic          rx_wp;
  logic          rx_rp;
  logic [1:0]    rx_fill;
  ump_tx_state_e tx_state;
  logic [8:0]    tx_buf;
  logic          tx_buf_ok;
  logic [12:0]   tx_sr;
  logic [3:0]    tx_left;
  logic [4:0]    tx_os;

  // build a transmit frame: start zero, data, optional parity, idle ones as stops
  function automatic logic [12:0] ump_tx_frame(input logic [8:0] d, input logic [3:0] nbits,
                                               input logic pe_on, input logic odd);
    ump_tx_frame = 13'h1FFE;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nbits) ump_tx_frame[i + 1] = d[i];
    end
    if (pe_on) ump_tx_frame[nbits + 4'h1] = ^d ^ odd;
  endfunction

  // apb phases and address decode
  wire logic acc      = psel_i & penable_i;
  wire logic setup    = psel_i & ~penable_i;
  wire logic sel_data = (paddr_i == OFS_DATA);
  wire logic sel_csra = (paddr_i == OFS_CSRA);
  wire logic sel_csrb = (paddr_i == OFS_CSRB);
  wire logic sel_csrc = (paddr_i == OFS_CSRC);
  wire logic sel_baud = (paddr_i == OFS_BAUD);
  wire logic mapped   = sel_data | sel_csra | sel_csrb | sel_csrc | sel_baud;
  wire logic wr_acc   = acc & pwrite_i;
  wire logic rd_data  = acc & ~pwrite_i & sel_data;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~mapped;

  // configuration fields
  wire logic       rxen  = ctl_b[CSRB_RXEN];
  wire logic       txen  = ctl_b[CSRB_TXEN];
  wire logic       mpf   = ctl_a[CSRA_MPF];
  wire logic       dspd  = ctl_a[CSRA_DSPD];
  wire logic       pen   = ctl_c[CSRC_PEN];
  wire logic       podd  = ctl_c[CSRC_PODD];
  wire logic       stop2 = ctl_c[CSRC_STOP2];
  wire logic [2:0] csz   = {ctl_b[CSRB_CSZ2], ctl_c[CSRC_CSZLO + 1:CSRC_CSZLO]};
  wire logic [3:0] nb    = ump_data_bits(csz);
  wire logic [8:0] cmask = ump_char_mask(csz);
  // [R20] oversampling rate select
  wire logic [4:0] ovs   = dspd ? OVS_DOUBLE : OVS_NORMAL;
  wire logic [4:0] vote  = dspd ? VOTE_DOUBLE : VOTE_NORMAL;

  ump_baud_gen u_baud (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .en_i      (rxen | txen | (tx_state == UMP_TX_SHIFT)),
    .div_i     (baud_div),
    .tick_o    (os_tick)
  );

  // receive sampling: majority of three centre samples, vote after the third
  wire logic rxd     = link.peer_txd;
  wire logic rx_maj  = (rx_win[1] & rx_win[0]) | (rx_win[1] & rxd) | (rx_win[0] & rxd);
  wire logic rx_wrap = (rx_cnt == ovs - 5'h01);
  // [R18] [R19] vote early, resync on every start
  wire logic rx_vote = os_tick & (rx_state != UMP_RX_IDLE) & (rx_cnt == vote + 5'h01);
  wire logic rx_last = (rx_idx == nb + {3'h0, pen});
  wire logic rx_done = rx_vote & (rx_state == UMP_RX_BITS) & rx_last & rxen;

  // [R3] [R4] frame type: ninth bit or first stop
  wire logic       rx_type  = (csz == CSZ_NINE) ? rx_bits[8] : rx_maj;
  // [R1] [R5] [R6] keep address frames, drop data when filtering
  wire logic       rx_keep  = rx_done & (~mpf | rx_type);
  // [R12] unused upper bits stored as zero
  wire logic [8:0] rx_data  = rx_bits[8:0] & cmask;
  wire logic       rx_pe    = pen & (^rx_data ^ podd ^ rx_bits[nb]);

  // [R16] flag follows fifo occupancy
  wire logic        rxc     = (rx_fill != 2'h0);
  wire logic        rx_full = (rx_fill == 2'h2);
  // [R22] only kept frames reach fifo and flags
  wire logic        rx_push = rx_keep & ~rx_full;
  // [R15] a data-port read advances the fifo only while it holds data
  wire logic        rx_pop  = rd_data & rxc;
  wire logic [10:0] rx_head = rxc ? rx_mem[rx_rp] : 11'h000;

  // receive state machine
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state <= UMP_RX_IDLE;
      rx_cnt   <= 5'h00;
      rx_idx   <= 4'h0;
      rx_win   <= 2'h3;
      rx_bits  <= 11'h000;
    end else if (!rxen) begin
      rx_state <= UMP_RX_IDLE;
    end else if (os_tick) begin
      rx_win <= {rx_win[0], rxd};
      unique case (rx_state)
        UMP_RX_IDLE: if (!rxd) begin
          rx_state <= UMP_RX_START;
          rx_cnt   <= 5'h01;
        end
        UMP_RX_START: begin
          rx_cnt <= rx_wrap ? 5'h00 : rx_cnt + 5'h01;
          if (rx_vote && rx_maj) begin
            rx_state <= UMP_RX_IDLE;
          end else if (rx_wrap) begin
            rx_state <= UMP_RX_BITS;
            rx_idx   <= 4'h0;
          end
        end
        UMP_RX_BITS: begin
          rx_cnt <= rx_wrap ? 5'h00 : rx_cnt + 5'h01;
          if (rx_vote) begin
            rx_bits[rx_idx] <= rx_maj;
            rx_idx          <= rx_idx + 4'h1;
            if (rx_last) rx_state <= UMP_RX_IDLE;
          end
        end
        default: rx_state <= UMP_RX_IDLE;
      endcase
    end
  end

  // fifo storage: framing error, parity error, nine data bits
  always_ff @(posedge sys_clk_i) begin
    if (rx_push) rx_mem[rx_wp] <= {~rx_maj, rx_pe, rx_data};
  end

  // fifo pointers and fill level
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_wp   <= 1'b0;
      rx_rp   <= 1'b0;
      rx_fill <= 2'h0;
    end else if (!rxen) begin
      // [R17] flush on receiver disable
      rx_wp   <= 1'b0;
      rx_rp   <= 1'b0;
      rx_fill <= 2'h0;
    end else begin
      if (rx_push) rx_wp <= ~rx_wp;
      if (rx_pop) rx_rp <= ~rx_rp;
      rx_fill <= rx_fill + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  // transmit side, independent of the filter setting
  // [R11] [R13] data-port write fills an empty buffer only
  wire logic tx_wr      = wr_acc & sel_data & ~tx_buf_ok;
  // [R2] [R14] load shifter when idle and enabled
  wire logic tx_load    = txen & tx_buf_ok & (tx_state == UMP_TX_IDLE);
  wire logic tx_bit_end = (tx_state == UMP_TX_SHIFT) & os_tick & (tx_os == ovs - 5'h01);
  wire logic tx_end     = tx_bit_end & (tx_left == 4'h1);
  assign link.dev_txd = tx_sr[0];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_buf    <= 9'h000;
      tx_buf_ok <= 1'b0;
      tx_state  <= UMP_TX_IDLE;
      tx_sr     <= 13'h1FFF;
      tx_left   <= 4'h0;
      tx_os     <= 5'h00;
    end else begin
      // [R12] unused upper bits dropped
      if (tx_wr) begin
        tx_buf    <= {ctl_b[CSRB_TX9], pwdata_i[7:0]} & cmask;
        tx_buf_ok <= 1'b1;
      end else if (tx_load) begin
        tx_buf_ok <= 1'b0;
      end
      if (tx_load) begin
        tx_sr    <= ump_tx_frame(tx_buf, nb, pen, podd);
        tx_left  <= 4'h2 + nb + {3'h0, pen} + {3'h0, stop2};
        tx_os    <= 5'h00;
        tx_state <= UMP_TX_SHIFT;
      end else if (tx_state == UMP_TX_SHIFT && os_tick) begin
        tx_os <= tx_bit_end ? 5'h00 : tx_os + 5'h01;
        if (tx_bit_end) begin
          tx_sr   <= {1'b1, tx_sr[12:1]};
          tx_left <= tx_left - 4'h1;
          if (tx_end) tx_state <= UMP_TX_IDLE;
        end
      end
    end
  end

  // control registers, sticky flags (set beats clear)
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_a    <= CSRA_RST & CSRA_WMASK;
      ctl_b    <= CSRB_RST;
      ctl_c    <= CSRC_RST;
      baud_div <= BAUD_RST;
      tx_complete_flag      <= CSRA_RST[CSRA_TXC];
      overrun_flag      <= CSRA_RST[CSRA_DOR];
    end else begin
      if (wr_acc && sel_csra) ctl_a <= pwdata_i[7:0] & CSRA_WMASK;
      if (wr_acc && sel_csrb) ctl_b <= pwdata_i[7:0] & CSRB_WMASK;
      if (wr_acc && sel_csrc) ctl_c <= pwdata_i[7:0] & CSRC_WMASK;
      if (wr_acc && sel_baud) baud_div <= pwdata_i[11:0];
      // [R21] set when shifter done and buffer empty
      tx_complete_flag <= (tx_end & ~tx_buf_ok) | (tx_complete_flag & ~(wr_acc & sel_csra & pwdata_i[CSRA_TXC]));
      // [R22] overrun only from kept frames
      overrun_flag <= (rx_keep & rx_full) | (overrun_flag & ~rx_pop & rxen);
    end
  end

  // read data, captured in the setup cycle
  wire logic [7:0]  csra_rd = {rxc, tx_complete_flag, ~tx_buf_ok, rx_head[10], overrun_flag, rx_head[9], ctl_a[1:0]};
  wire logic [7:0]  csrb_rd = ctl_b | {6'h00, rx_head[8], 1'b0};
  wire logic [31:0] rd_word = sel_data ? {24'h000000, rx_head[7:0]} :
                              sel_csra ? {24'h000000, csra_rd} :
                              sel_csrb ? {24'h000000, csrb_rd} :
                              sel_csrc ? {24'h000000, ctl_c} :
                              sel_baud ? {20'h00000, baud_div} : 32'h00000000;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (setup && !pwrite_i) begin
      prdata_o <= rd_word;
    end
  end
endmodule

// [dv/ump_monitor.sv]
// ump_monitor: bus and serial line checks beside the link
`timescale 1ns/1ps
module ump_monitor
  import ump_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] prdata_i,
  input wire logic        pready_i,
  input wire logic        pslverr_i,
  input wire logic        send_i,
  input wire logic        ready_i,
  input wire logic        dev_txd_i,
  input wire logic        peer_txd_i
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // access phase decode
  wire acc     = psel_i & penable_i;
  wire rd_data = acc & !pwrite_i & (paddr_i == OFS_DATA);

  property p_no_wait; acc |-> pready_i; endproperty
  a_no_wait: assert property (p_no_wait) else $error("wait state seen");
  property p_unmapped; acc && (paddr_i > OFS_BAUD) |-> pslverr_i; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  property p_mapped; acc && (paddr_i == OFS_DATA) |-> !pslverr_i; endproperty
  a_mapped: assert property (p_mapped) else $error("false slave error");
  property p_upper_zero; rd_data |-> (prdata_i[31:8] == 24'h000000); endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_idle_line; $rose(rst_n_i) |-> dev_txd_i && peer_txd_i; endproperty
  a_idle_line: assert property (p_idle_line) else $error("line not idle");
  property p_dev_start; $fell(dev_txd_i) |-> !dev_txd_i [*8]; endproperty
  a_dev_start: assert property (p_dev_start) else $error("short start bit");
  property p_peer_take; send_i && ready_i |=> !ready_i && !peer_txd_i; endproperty
  a_peer_take: assert property (p_peer_take) else $error("send not taken");
  property p_peer_idle; ready_i |-> peer_txd_i; endproperty
  a_peer_idle: assert property (p_peer_idle) else $error("idle line low");
  property p_peer_start; $fell(peer_txd_i) |-> !peer_txd_i [*8]; endproperty
  a_peer_start: assert property (p_peer_start) else $error("short peer start");

  // main scenarios
  c_err: cover property (acc && pslverr_i);
  c_dev: cover property ($fell(dev_txd_i));
  c_take: cover property (send_i && ready_i);
endmodule

// [dv/uart_multiproc_rx_buffer_tb_top.sv]
// uart_multiproc_rx_buffer_tb_top: port and peer facing each other, driven over apb
`timescale 1ns/1ps
`define CHECK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module uart_multiproc_rx_buffer_tb_top import ump_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        send    = 1'b0;
  logic        addr_fr = 1'b0;
  logic [7:0]  pdata   = 8'h00;
  logic        peer_rdy;
  logic [11:0] peer_div = 12'h000;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          checks    = 0;

  ump_link_if link ();
  ump_usart ump_usart_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(link.dev));
  ump_peer ump_peer_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .baud_div_i(peer_div), .send_i(send),
    .addr_frame_i(addr_fr), .data_i(pdata), .ready_o(peer_rdy), .link(link.peer));
  ump_monitor ump_monitor_i (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
    .send_i(send), .ready_i(peer_rdy), .dev_txd_i(link.dev_txd), .peer_txd_i(link.peer_txd));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // a spent bound counts as a mismatch
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      print_verdict();
    end
  endtask

  // one apb transfer, answer taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    tmo(n, 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHECK(nm, e, rd)
  endtask

  // peer sends one frame and returns to idle
  task automatic psend(input logic a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    addr_fr <= a;
    pdata   <= d;
    send    <= 1'b1;
    @(posedge sys_clk);
    send <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (peer_rdy !== 1'b1 && n < 5000);
    tmo(n, 5000);
    repeat (3) @(posedge sys_clk);
  endtask

  // capture one eight bit frame from the port, 16 clocks a bit
  task automatic txchk(input logic [7:0] e);
    int n;
    logic [7:0] v;
    n = 0;
    while (link.dev_txd !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    tmo(n, 300);
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge sys_clk);
      v[i] = link.dev_txd;
    end
    repeat (16) @(posedge sys_clk);
    `CHECK("tx stop", 1'b1, link.dev_txd)
    `CHECK("tx byte", e, v)
  endtask

  task automatic t_reset();
    rchk(OFS_CSRA, 32'h20, "csra reset");
    rchk(OFS_CSRC, 32'h06, "csrc reset");
    apb(1'b1, OFS_CSRA, 32'hFC);
    rchk(OFS_CSRA, 32'h20, "read only bits");
    apb(1'b0, 8'h14, 32'h0);
    `CHECK("unmapped error", 1'b1, err)
  endtask

  task automatic t_filter();
    apb(1'b1, OFS_CSRB, 32'h1C);
    apb(1'b1, OFS_CSRA, 32'h01);
    psend(1'b0, 8'h55);
    rchk(OFS_CSRA, 32'h21, "data dropped");
    psend(1'b1, 8'hA3);
    rchk(OFS_CSRA, 32'hA1, "address kept");
    rchk(OFS_CSRB, 32'h1E, "ninth one");
    rchk(OFS_DATA, 32'hA3, "address byte");
    apb(1'b1, OFS_CSRA, 32'h00);
    psend(1'b0, 8'h3C);
    rchk(OFS_CSRB, 32'h1C, "ninth zero");
    rchk(OFS_DATA, 32'h3C, "data byte");
  endtask

  task automatic t_fifo();
    psend(1'b0, 8'h11);
    psend(1'b0, 8'h22);
    psend(1'b0, 8'h33);
    rchk(OFS_CSRA, 32'hA8, "full overrun");
    rchk(OFS_DATA, 32'h11, "first");
    rchk(OFS_DATA, 32'h22, "second");
    rchk(OFS_CSRA, 32'h20, "empty");
    rchk(OFS_DATA, 32'h0, "empty read");
    psend(1'b0, 8'h44);
    apb(1'b1, OFS_CSRB, 32'h0C);
    apb(1'b1, OFS_CSRB, 32'h1C);
    rchk(OFS_CSRA, 32'h20, "flushed");
  endtask

  task automatic t_short();
    apb(1'b1, OFS_CSRB, 32'h18);
    apb(1'b1, OFS_CSRA, 32'h01);
    psend(1'b0, 8'h66);
    rchk(OFS_CSRA, 32'h21, "no error flags");
    psend(1'b1, 8'h99);
    rchk(OFS_DATA, 32'h99, "stop as type");
    apb(1'b1, OFS_CSRA, 32'h00);
    apb(1'b1, OFS_CSRC, 32'h00);
    psend(1'b1, 8'hFF);
    rchk(OFS_DATA, 32'h1F, "five bits");
    apb(1'b1, OFS_CSRC, 32'h06);
  endtask

  // peer at 96 percent of the port rate, then double speed
  task automatic t_rate();
    peer_div <= 12'h018;
    apb(1'b1, OFS_BAUD, 32'h17);
    psend(1'b1, 8'hC6);
    rchk(OFS_DATA, 32'hC6, "slow peer");
    peer_div <= 12'h000;
    apb(1'b1, OFS_BAUD, 32'h01);
    apb(1'b1, OFS_CSRA, 32'h02);
    psend(1'b1, 8'h5C);
    rchk(OFS_DATA, 32'h5C, "double speed");
    rchk(OFS_CSRA, 32'h22, "eight samples a bit");
    apb(1'b1, OFS_CSRA, 32'h00);
    apb(1'b1, OFS_BAUD, 32'h00);
  endtask

  // third write lands while the buffer is full
  task automatic t_tx();
    apb(1'b1, OFS_CSRA, 32'h01);
    fork
      begin
        txchk(8'hA5);
        txchk(8'h5A);
      end
      begin
        apb(1'b1, OFS_DATA, 32'hA5);
        apb(1'b1, OFS_DATA, 32'h5A);
        apb(1'b1, OFS_DATA, 32'hFF);
      end
    join
    repeat (20) @(posedge sys_clk);
    rchk(OFS_CSRA, 32'h61, "tx complete");
    apb(1'b1, OFS_CSRA, 32'h41);
    rchk(OFS_CSRA, 32'h21, "complete cleared");
  endtask

  // reset, then every scenario in turn
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_filter();
    t_fifo();
    t_short();
    t_rate();
    t_tx();
    print_verdict();
  end
endmodule
